// ### dcs_regs.svh
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH
`define DCS_CLK_HZ        100000000
`define DCS_BAUD          57600
`define DCS_BAUD_DIV      (`DCS_CLK_HZ / `DCS_BAUD)
`define DCS_SAMPLE_HZ     5000000
`define DCS_SAMPLE_DIV    (`DCS_CLK_HZ / `DCS_SAMPLE_HZ)
`define DCS_WINDOW_US     10500
`define DCS_WINDOW_SAMPLES ((`DCS_WINDOW_US * (`DCS_SAMPLE_HZ / 1000)) / 1000)
`define DCS_NO_SIGNAL     16'hffff
`define DCS_CHR_M         8'h6d
`define DCS_CHR_S         8'h73
`define DCS_CHR_1         8'h31
`define DCS_CHR_8         8'h38
`define DCS_CHR_0         8'h30
`define DCS_CHR_A_OFS     8'h57
`define DCS_CHR_SP        8'h20
`define DCS_CHR_CR        8'h0d
`define DCS_CHR_LF        8'h0a
`define DCS_TX_BITS       4'h9
`endif

// ### dcs_pkg.sv
package dcs_pkg;
   typedef enum logic [2:0]
   {
      DCS_IDLE  = 3'b000,
      DCS_MEAS  = 3'b001,
      DCS_EMIT  = 3'b010,
      DCS_NEXT  = 3'b011
   } dcs_state_t;
endpackage

// ### dcs_scanner.sv
// Notes on behaviour
// - Only the sensor being measured has its power output on; all others stay off.
// - Each sensor is powered for at most 10.5 ms per measurement, then the scan moves on.
// - The selector lines route exactly the sensor under measurement to the measurement input.
// - The selected signal is sampled at 5 MHz over a 10.5 ms window counting high and low samples.
// - All selected sensors are measured first and the results are sent only after the scan ends.
// - The serial link runs at 57600 baud, 8 data bits, no parity, one stop bit, no flow control.
// - Receiving m starts a continuous stream of repeated scans.
// - An unconnected sensor position reports FFFF in place of its times.
// - Each time is four ASCII hex digits, a space between the pair and CR LF after each sensor.
// - Receiving digit 1 to 8 runs one single pass over that many sensors from the first.
// - A sensor with no period-modulated signal in its window reports FFFF for both times.
`timescale 1ns/1ns
`include "dcs_regs.svh"
module dcs_scanner
   import dcs_pkg::*;
#(
   parameter int NUM_SENSORS = 8,
   parameter int WINDOW_SAMPLES = `DCS_WINDOW_SAMPLES,
   parameter int BAUD_DIV = `DCS_BAUD_DIV
)
(
   input  wire logic                   i_mclk,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_sense,
   input  wire logic                   i_rxd,
   output logic [NUM_SENSORS-1:0]      o_sensor_pwr,
   output logic [2:0]                  o_sel,
   output logic                        o_txd,
   output logic                        o_busy
);
   localparam int CW = $clog2(WINDOW_SAMPLES + 1);
   localparam int BW = $clog2(BAUD_DIV + 1);

   // ---------------- serial receiver
   logic [BW-1:0]  rx_cnt_r;
   logic [3:0]     rx_bit_r;
   logic [7:0]     rx_sh_r;
   logic           rx_act_r;
   logic           rx_stb_r;
   logic [7:0]     rx_byte_r;
   wire            rx_tick = (rx_cnt_r == '0);
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         rx_cnt_r  <= '0;
         rx_bit_r  <= 4'h0;
         rx_sh_r   <= 8'h00;
         rx_act_r  <= 1'b0;
         rx_stb_r  <= 1'b0;
         rx_byte_r <= 8'h00;
      end
      else
      begin
         rx_stb_r <= 1'b0;
         if (!rx_act_r)
         begin
            if (!i_rxd)
            begin
               rx_act_r <= 1'b1;
               rx_bit_r <= 4'h0;
               rx_cnt_r <= BW'(BAUD_DIV / 2); // sample mid-bit
            end
         end
         else if (rx_tick)
         begin
            rx_cnt_r <= BW'(BAUD_DIV - 1);
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0 && i_rxd)
               rx_act_r <= 1'b0;
            else if (rx_bit_r >= 4'h1 && rx_bit_r <= 4'h8)
               rx_sh_r <= {i_rxd, rx_sh_r[7:1]};
            else if (rx_bit_r == `DCS_TX_BITS)
            begin
               rx_act_r <= 1'b0;
               if (i_rxd)
               begin
                  rx_stb_r  <= 1'b1;
                  rx_byte_r <= rx_sh_r;
               end
            end
         end
         else
            rx_cnt_r <= rx_cnt_r - BW'(1);
      end
   end

   wire cmd_m   = rx_stb_r && rx_byte_r == `DCS_CHR_M;
   wire cmd_s   = rx_stb_r && rx_byte_r == `DCS_CHR_S;
   wire cmd_num = rx_stb_r && rx_byte_r >= `DCS_CHR_1 && rx_byte_r <= `DCS_CHR_8;
   wire [3:0] cmd_cnt = 4'(rx_byte_r - `DCS_CHR_0);

   // ---------------- measurement and emit sequencer
   dcs_state_t      st_r;
   logic            cont_r;
   logic [3:0]      last_r;
   logic [3:0]      idx_r;
   logic [6:0]      div_r;
   logic [CW-1:0]   win_r;
   logic [15:0]     hi_r;
   logic [15:0]     lo_r;
   logic            prev_r;
   logic [15:0]     edges_r;
   logic [15:0]     res_hi [NUM_SENSORS];
   logic [15:0]     res_lo [NUM_SENSORS];
   logic [3:0]      ch_r;
   logic [3:0]      pos_r;

   wire samp    = (div_r == 7'(`DCS_SAMPLE_DIV - 1));
   wire win_end = samp && (win_r == CW'(WINDOW_SAMPLES - 1));
   // need two transitions and each level seen at least once
   wire valid_sig = (edges_r >= 16'h0002) && hi_r != '0 && lo_r != '0;

   // emit byte selection
   logic [15:0] word;
   logic [3:0]  nib;
   logic [7:0]  emit_ch;
   assign word = (pos_r < 4'h5) ? res_hi[ch_r[2:0]] : res_lo[ch_r[2:0]];
   assign nib  = (pos_r == 4'h0 || pos_r == 4'h5) ? word[15:12] :
                 (pos_r == 4'h1 || pos_r == 4'h6) ? word[11:8]  :
                 (pos_r == 4'h2 || pos_r == 4'h7) ? word[7:4]   : word[3:0];
   assign emit_ch = (pos_r == 4'h4) ? `DCS_CHR_SP :
                    (pos_r == 4'h9) ? `DCS_CHR_CR :
                    (pos_r == 4'ha) ? `DCS_CHR_LF :
                    (nib < 4'ha) ? (`DCS_CHR_0 + 8'(nib)) : (`DCS_CHR_A_OFS + 8'(nib));

   // two-entry buffer feeding the transmitter
   logic [7:0] fb_d [2];
   logic [1:0] fb_cnt_r;
   logic       fb_rd_r;
   logic       fb_wr_r;
   wire        fb_in_ready  = (fb_cnt_r != 2'd2);
   wire        fb_out_valid = (fb_cnt_r != 2'd0);
   logic       tx_ready;
   wire        emit_done = (ch_r == last_r);
   wire        push = (st_r == DCS_EMIT) && fb_in_ready && !emit_done;
   wire        pop  = fb_out_valid && tx_ready;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         st_r    <= DCS_IDLE;
         cont_r  <= 1'b0;
         last_r  <= 4'h0;
         idx_r   <= 4'h0;
         div_r   <= 7'h00;
         win_r   <= '0;
         hi_r    <= 16'h0000;
         lo_r    <= 16'h0000;
         prev_r  <= 1'b0;
         edges_r <= 16'h0000;
         ch_r    <= 4'h0;
         pos_r   <= 4'h0;
      end
      else if (cmd_s)
      begin
         st_r   <= DCS_IDLE;
         cont_r <= 1'b0;
      end
      else
      begin
         unique case (st_r)
            DCS_IDLE:
            begin
               if (cmd_m || cmd_num)
               begin
                  st_r    <= DCS_MEAS;
                  cont_r  <= cmd_m;
                  last_r  <= cmd_m ? 4'(NUM_SENSORS) : cmd_cnt;
                  idx_r   <= 4'h0;
                  div_r   <= 7'h00;
                  win_r   <= '0;
                  hi_r    <= 16'h0000;
                  lo_r    <= 16'h0000;
                  edges_r <= 16'h0000;
                  prev_r  <= i_sense;
               end
            end
            DCS_MEAS:
            begin
               div_r <= samp ? 7'h00 : div_r + 7'h01;             // 5 MHz sample tick
               if (samp)
               begin
                  win_r  <= win_r + CW'(1);
                  prev_r <= i_sense;
                  if (i_sense)
                     hi_r <= hi_r + 16'h0001;
                  else
                     lo_r <= lo_r + 16'h0001;
                  if (i_sense != prev_r && edges_r != 16'hffff)
                     edges_r <= edges_r + 16'h0001;
               end
               if (win_end)                                       // power off at window end
               begin
                  st_r <= DCS_NEXT;
               end
            end
            DCS_NEXT:
            begin
               // counts now hold the last sample of the window as well
               res_hi[idx_r[2:0]] <= valid_sig ? hi_r : `DCS_NO_SIGNAL;
               res_lo[idx_r[2:0]] <= valid_sig ? lo_r : `DCS_NO_SIGNAL;
               hi_r    <= 16'h0000;
               lo_r    <= 16'h0000;
               edges_r <= 16'h0000;
               win_r   <= '0;
               div_r   <= 7'h00;
               prev_r  <= i_sense;
               if (idx_r + 4'h1 < last_r)
               begin
                  idx_r <= idx_r + 4'h1;
                  st_r  <= DCS_MEAS;
               end
               else
               begin
                  ch_r  <= 4'h0;
                  pos_r <= 4'h0;
                  st_r  <= DCS_EMIT;                              // send after whole scan
               end
            end
            DCS_EMIT:
            begin
               if (push)
               begin
                  pos_r <= (pos_r == 4'ha) ? 4'h0 : pos_r + 4'h1;
                  if (pos_r == 4'ha)
                     ch_r <= ch_r + 4'h1;
               end
               // wait for the line to drain so the next window sees a quiet link
               if (emit_done && !fb_out_valid && tx_ready)
               begin
                  idx_r <= 4'h0;
                  st_r  <= cont_r ? DCS_MEAS : DCS_IDLE;
               end
            end
            default:
               st_r <= DCS_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         fb_cnt_r <= 2'd0;
         fb_rd_r  <= 1'b0;
         fb_wr_r  <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            fb_d[fb_wr_r] <= emit_ch;
            fb_wr_r       <= ~fb_wr_r;
         end
         if (pop)
            fb_rd_r <= ~fb_rd_r;
         fb_cnt_r <= fb_cnt_r + 2'(push) - 2'(pop);
      end
   end

   // ---------------- serial transmitter
   logic [BW-1:0] tx_cnt_r;
   logic [3:0]    tx_bit_r;
   logic [8:0]    tx_sh_r;
   logic          tx_act_r;
   assign tx_ready = !tx_act_r;
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         tx_cnt_r <= '0;
         tx_bit_r <= 4'h0;
         tx_sh_r  <= 9'h1ff;
         tx_act_r <= 1'b0;
         o_txd    <= 1'b1;
      end
      else if (pop)
      begin
         tx_act_r <= 1'b1;
         tx_sh_r  <= {1'b1, fb_d[fb_rd_r]};                       // 8N1 frame
         tx_bit_r <= 4'h0;
         tx_cnt_r <= BW'(BAUD_DIV - 1);
         o_txd    <= 1'b0;
      end
      else if (tx_act_r)
      begin
         if (tx_cnt_r == '0)
         begin
            tx_cnt_r <= BW'(BAUD_DIV - 1);
            if (tx_bit_r == `DCS_TX_BITS)
               tx_act_r <= 1'b0;
            else
            begin
               o_txd    <= tx_sh_r[0];
               tx_sh_r  <= {1'b1, tx_sh_r[8:1]};
               tx_bit_r <= tx_bit_r + 4'h1;
            end
         end
         else
            tx_cnt_r <= tx_cnt_r - BW'(1);
      end
   end

   // ---------------- sensor power and selector outputs
   genvar g;
   generate
      for (g = 0; g < NUM_SENSORS; g++)
      begin : g_pwr
         always_ff @(posedge i_mclk)
         begin
            if (!i_rst_n)
               o_sensor_pwr[g] <= 1'b0;
            else
               o_sensor_pwr[g] <= (st_r == DCS_MEAS) && !win_end && !cmd_s && (idx_r == 4'(g));
         end
      end
   endgenerate

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         o_sel  <= 3'h0;
         o_busy <= 1'b0;
      end
      else
      begin
         o_sel  <= idx_r[2:0];
         o_busy <= (st_r != DCS_IDLE);
      end
   end
endmodule

// ### dcs_scanner_checker.sv
`timescale 1ns/1ns
module dcs_scanner_checker
#(
   parameter int NUM_SENSORS    = 8,
   parameter int WINDOW_SAMPLES = 50,
   parameter int BAUD_DIV       = 16
)
(
   input wire logic                   i_mclk,
   input wire logic                   i_rst_n,
   input wire logic                   i_sense,
   input wire logic                   i_rxd,
   input wire logic [NUM_SENSORS-1:0] o_sensor_pwr,
   input wire logic [2:0]             o_sel,
   input wire logic                   o_txd,
   input wire logic                   o_busy
);
   int on_cnt_r;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // consecutive cycles with a sensor powered
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n || o_sensor_pwr == '0)
         on_cnt_r <= 0;
      else
         on_cnt_r <= on_cnt_r + 1;
   end
   sequence sensor_step;
      (o_sensor_pwr != '0) ##1 (o_sensor_pwr == '0) [*2] ##1 (o_sensor_pwr != '0);
   endsequence
   chk_pwr_one_hot: assert property ($onehot0(o_sensor_pwr))
      else $error("more than one sensor powered");
   chk_pwr_max_on: assert property (on_cnt_r <= WINDOW_SAMPLES * 20)
      else $error("sensor powered longer than its window");
   chk_pwr_sel_match: assert property (o_sensor_pwr != '0 |-> o_sensor_pwr[o_sel])
      else $error("powered sensor differs from selected one");
   chk_scan_quiet_tx: assert property (o_sensor_pwr != '0 |-> o_txd && o_busy)
      else $error("serial output active during a measurement");
   chk_frame_start: assert property ($fell(o_txd) |-> (!o_txd) [*8])
      else $error("start bit too short");
   chk_idle_pwr_off: assert property (!o_busy [*2] |-> o_sensor_pwr == '0)
      else $error("sensor powered while idle");
   chk_scan_first: assert property ($rose(o_busy) |-> ##[0:3] (o_sensor_pwr[0] && o_sel == 3'h0))
      else $error("scan did not start at the first sensor");
   chk_scan_order: assert property (sensor_step |-> o_sel == $past(o_sel, 3) + 3'h1)
      else $error("sensors not scanned in ascending order");
endmodule

bind dcs_scanner dcs_scanner_checker #(.NUM_SENSORS(NUM_SENSORS), .WINDOW_SAMPLES(WINDOW_SAMPLES),
   .BAUD_DIV(BAUD_DIV)) u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sense(i_sense), .i_rxd(i_rxd),
   .o_sensor_pwr(o_sensor_pwr), .o_sel(o_sel), .o_txd(o_txd), .o_busy(o_busy));

// ### dcs_host.sv
`timescale 1ns/1ns
module dcs_host
#(
   parameter int BAUD_DIV = 16
)
(
   input  wire logic i_mclk,
   input  wire logic i_txd,
   output logic      o_rxd
);
   logic [7:0] rx_q[$];
   logic [7:0] sh;
   initial o_rxd = 1'b1;
   // 8n1, lsb first, line left at mark level between frames
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         o_rxd <= f[i];
         repeat (BAUD_DIV) @(posedge i_mclk);
      end
   endtask
   // receiver samples mid-bit, keeps only bytes with a valid stop bit
   always
   begin
      @(negedge i_txd);
      repeat (BAUD_DIV / 2) @(posedge i_mclk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BAUD_DIV) @(posedge i_mclk);
         sh[i] = i_txd;
      end
      repeat (BAUD_DIV) @(posedge i_mclk);
      if (i_txd === 1'b1)
         rx_q.push_back(sh);
   end
endmodule

// ### dcs_scanner_tb.sv
`timescale 1ns/1ns
module dcs_scanner_tb;
   localparam int NS = 8;
   localparam int WS = 20;
   localparam int BD = 10;
   logic          i_mclk;
   logic          i_rst_n;
   logic          i_sense;
   wire logic     i_rxd;
   logic [NS-1:0] o_sensor_pwr;
   logic [2:0]    o_sel;
   logic          o_txd;
   logic          o_busy;
   logic [7:0]    ph_r;
   int            failures;
   int            cmp_count;

   dcs_scanner #(.NUM_SENSORS(NS), .WINDOW_SAMPLES(WS), .BAUD_DIV(BD)) dut (.i_mclk(i_mclk),
      .i_rst_n(i_rst_n), .i_sense(i_sense), .i_rxd(i_rxd), .o_sensor_pwr(o_sensor_pwr),
      .o_sel(o_sel), .o_txd(o_txd), .o_busy(o_busy));
   dcs_host #(.BAUD_DIV(BD)) host (.i_mclk(i_mclk), .i_txd(o_txd), .o_rxd(i_rxd));

   initial i_mclk = 1'b0;
   always #5 i_mclk = ~i_mclk;

   // sensor 1 stuck high, sensor 7 absent, others a 200-cycle wave high 20*(k+1)
   always @(posedge i_mclk)
   begin
      ph_r <= (ph_r == 8'hc7) ? 8'h00 : ph_r + 8'h01;
      i_sense <= (o_sel == 3'h1) || (o_sel != 3'h7 && ph_r < 20 * (o_sel + 1));
   end

   task automatic close_out();
      if (failures == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // window phase may shift one sample, so counts allow one step
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp && (exp === 16'hffff || (got !== exp + 16'h1 && got !== exp - 16'h1)))
      begin
         failures++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic logic [3:0] hexv(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39)
         return 4'(c - 8'h30);
      if (c >= 8'h61 && c <= 8'h66)
         return 4'(c - 8'h57);
      return 4'hx;
   endfunction

   task automatic check_rows(input int n);
      logic [7:0]  b[11];
      logic [15:0] eh;
      chk8(8'(host.rx_q.size()), 8'(n * 11));
      for (int k = 0; k < n && host.rx_q.size() >= 11; k++)
      begin
         foreach (b[j])
            b[j] = host.rx_q.pop_front();
         eh = (k == 1 || k == 7) ? 16'hffff : 16'(WS / 10 * (k + 1));
         chk16({hexv(b[0]), hexv(b[1]), hexv(b[2]), hexv(b[3])}, eh);
         chk8(b[4], 8'h20);
         chk16({hexv(b[5]), hexv(b[6]), hexv(b[7]), hexv(b[8])}, (eh == 16'hffff) ? eh : 16'(WS) - eh);
         chk8(b[9], 8'h0d);
         chk8(b[10], 8'h0a);
      end
   endtask

   task automatic t_ignore();
      logic [7:0] junk[3] = '{8'h78, 8'h30, 8'h39};
      foreach (junk[i])
      begin
         host.send_byte(junk[i]);
         repeat (4 * BD) @(posedge i_mclk);
         chk8({7'h0, o_busy}, 8'h00);
      end
   endtask

   task automatic t_digits();
      for (int n = 1; n <= 8; n++)
      begin
         host.rx_q.delete();
         host.send_byte(8'(8'h30 + n));
         host.send_byte(8'h31);
         for (int i = 0; i < 30000 && o_busy !== 1'b0; i++)
            @(posedge i_mclk);
         chk8({7'h0, o_busy}, 8'h00);
         repeat (4 * BD) @(posedge i_mclk);
         check_rows(n);
      end
   endtask

   task automatic t_stream();
      host.rx_q.delete();
      host.send_byte(8'h6d);
      for (int i = 0; i < 20000 && host.rx_q.size() < 88; i++)
         @(posedge i_mclk);
      repeat (4 * BD) @(posedge i_mclk);
      chk8({7'h0, o_busy}, 8'h01);
      check_rows(8);
      host.send_byte(8'h73);
      repeat (3) @(posedge i_mclk);
      chk8({7'h0, o_busy}, 8'h00);
      chk8(o_sensor_pwr, 8'h00);
      repeat (2000) @(posedge i_mclk);
      chk8(8'(host.rx_q.size()), 8'h00);
   endtask

   initial
   begin
      i_rst_n = 1'b0;
      i_sense = 1'b0;
      ph_r = 8'h00;
      failures = 0;
      cmp_count = 0;
      repeat (3) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(posedge i_mclk);
      chk8(o_sensor_pwr, 8'h00);
      chk8({3'h0, o_busy, o_txd, o_sel}, 8'h08);
      t_ignore();
      t_digits();
      t_stream();
      close_out();
   end

   initial
   begin
      repeat (95000) @(posedge i_mclk);
      failures++;
      close_out();
   end
endmodule
